// ===== rtl/mcs_pkg.sv
// Purpose: constants for the measuring circuit supervision block
// Assumes: 10 MHz pclk, APB register access, magnitudes from the measuring chain
// Notes: register offsets are byte addresses
// Contract
// - ratio correction derived from configured phase and earth ct ratings
// - limit is deviation threshold plus dynamic factor times largest phase current
// - ct failure when 3*i0 plus corrected earth current reaches limit
// - potential loss needs one phase voltage below a hundredth of nominal
// - needs residual voltage below 0.01 nominal or v2/v1 above 40 percent
// - needs all three phase currents below the low current threshold
// - needs residual current below one tenth of rated current
// - needs no pickup of an overcurrent element assigned to block
// - needs breaker closed when one is assigned, else breaker ignored
// - needs offline detection not reporting a dead busbar
// - potential loss condition true only when all conditions hold together
// - potential loss alarm only after the alarm delay with condition present
// - loss of potential blocks elements only with block enable set
// - an element is blocked only when its own supervision setting is active
// - phase vt fuse input signals fuse failure and blocks supervised elements
// - earth vt fuse input acts the same as phase vt fuse input
package mcs_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_DEV_THR = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_KD = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_PH_PRI = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_PH_SEC = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_E_PRI = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_E_SEC = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_VNOM = 8'h1c;
    localparam logic [ADDR_W-1:0] OFF_I_LOW = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_I_RATED = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_T_ALARM = 8'h28;
    localparam logic [ADDR_W-1:0] OFF_OC_MASK = 8'h2c;
    localparam logic [ADDR_W-1:0] OFF_ELEM_SUP = 8'h30;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h34;
    localparam logic [ADDR_W-1:0] OFF_EVENT = 8'h38;
    localparam logic [ADDR_W-1:0] OFF_MASK = 8'h3c;
    localparam logic [ADDR_W-1:0] OFF_KI = 8'h40;
    // control bits
    localparam int CTL_CTS_EN = 0;
    localparam int CTL_BLOCK_EN = 1;
    localparam int CTL_BRK_ASSIGN = 2;
    localparam int CTL_VT_FUSE_ASSIGN = 3;
    localparam int CTL_EVT_FUSE_ASSIGN = 4;
    localparam int CTL_W = 5;
    localparam logic [CTL_W-1:0] CTRL_RESET = 5'h00;
    // status and event bits
    localparam int ST_CTS_FAIL = 0;
    localparam int ST_LOP_ALARM = 1;
    localparam int ST_VT_FUSE = 2;
    localparam int ST_EVT_FUSE = 3;
    localparam int EV_W = 4;
    localparam int ST_LOP_COND = 4;
    localparam int ST_BLOCK = 5;
    localparam int ST_RATIO_BUSY = 6;
    localparam int ST_W = 7;
    // fixed point formats: ki q8.8, kd q0.8
    localparam int KI_FRAC = 8;
    localparam int KD_FRAC = 8;
    localparam logic [15:0] KI_RESET = 16'h0100;
    localparam logic [15:0] RATING_RESET = 16'h0001;
    // measured quantity ratios
    localparam logic signed [17:0] RESID_MULT = 18'sh00003;
    localparam logic [23:0] VNOM_DIV = 24'h000064;
    localparam logic [23:0] PCT_FULL = 24'h000064;
    localparam logic [23:0] NEG_SEQ_PCT = 24'h000028;
    localparam logic [43:0] I_RATED_DIV = 44'h00000000064;
    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int ALARM_UNIT_NS = 1000000;
    localparam int CYC_PER_UNIT = ALARM_UNIT_NS / CLK_PERIOD_NS;
endpackage

// ===== rtl/mcs_ratio_div.sv
// Purpose: serial restoring divider producing a saturated quotient
// Assumes: start may arrive at any time and restarts the division
// Notes: a zero divisor yields a zero quotient
`timescale 1ns/1ps
`default_nettype none
module mcs_ratio_div #(
    parameter int NW = 40,
    parameter int DW = 32,
    parameter int QW = 16
) (
    input wire logic pclk, // block clock
    input wire logic presetn, // async reset, active low
    input wire logic start, // one-cycle pulse, loads operands
    input wire logic [NW-1:0] num, // dividend
    input wire logic [DW-1:0] den, // divisor
    output logic busy, // division running
    output logic done, // one-cycle pulse, quotient updated
    output logic [QW-1:0] quot // saturated quotient
);
    localparam int CW = $clog2(NW + 1);
    logic [DW:0] rem_q;
    logic [NW-1:0] n_q;
    logic [DW-1:0] den_q;
    logic [CW-1:0] cnt_q;
    logic [DW:0] trial;

    assign trial = {rem_q[DW-1:0], n_q[NW-1]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rem_q <= '0;
            n_q <= '0;
            den_q <= '0;
            cnt_q <= '0;
            busy <= 1'b0;
        end else if (start) begin
            rem_q <= '0;
            n_q <= num;
            den_q <= den;
            cnt_q <= CW'(NW);
            busy <= 1'b1;
        end else if (busy) begin
            // quotient bits shift into n_q as the dividend shifts out
            if (trial >= {1'b0, den_q}) begin
                rem_q <= trial - {1'b0, den_q};
                n_q <= {n_q[NW-2:0], 1'b1};
            end else begin
                rem_q <= trial;
                n_q <= {n_q[NW-2:0], 1'b0};
            end
            cnt_q <= cnt_q - 1'b1;
            busy <= (cnt_q != CW'(1));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done <= 1'b0;
        end else begin
            done <= busy && !start && (cnt_q == CW'(1));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quot <= '0;
        end else if (done) begin
            if (den_q == '0) begin
                quot <= '0;
            end else if (|n_q[NW-1:QW]) begin
                quot <= '1;
            end else begin
                quot <= n_q[QW-1:0];
            end
        end
    end
endmodule
`default_nettype wire

// ===== rtl/mcs_top.sv
// Purpose: ct failure and loss of potential supervision with element blocking
// Assumes: magnitudes and phasors arrive from same-clock logic; fuse and breaker are pins
// Notes: one apb slave, zero wait states, one level interrupt
`timescale 1ns/1ps
`default_nettype none
module mcs_top #(
    parameter int NUM_OC = 8,
    parameter int NUM_ELEM = 8,
    parameter int UNIT_CYCLES = mcs_pkg::CYC_PER_UNIT
) (
    input wire logic pclk, // 10 MHz clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [mcs_pkg::ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic signed [15:0] i0_re, // zero-sequence current, real
    input wire logic signed [15:0] i0_im, // zero-sequence current, imaginary
    input wire logic signed [15:0] earth_re, // measured_earth_current, real
    input wire logic signed [15:0] earth_im, // measured_earth_current, imaginary
    input wire logic [15:0] ia, // phase a current magnitude
    input wire logic [15:0] ib, // phase b current magnitude
    input wire logic [15:0] ic, // phase c current magnitude
    input wire logic [15:0] va, // phase a voltage magnitude
    input wire logic [15:0] vb, // phase b voltage magnitude
    input wire logic [15:0] vc, // phase c voltage magnitude
    input wire logic [15:0] v_resid, // residual voltage magnitude
    input wire logic [15:0] v_pos, // positive sequence voltage
    input wire logic [15:0] v_neg, // negative sequence voltage
    input wire logic [NUM_OC-1:0] oc_pickup, // overcurrent element pickups
    input wire logic dead_bus, // offline detection reports dead busbar
    input wire logic breaker_closed, // breaker position pin
    input wire logic phase_vt_fuse_input, // phase vt breaker tripped pin
    input wire logic earth_vt_fuse_input, // earth vt breaker tripped pin
    output logic cts_alarm, // ct failure alarm
    output logic potential_loss_block, // delayed loss of potential alarm
    output logic [NUM_ELEM-1:0] elem_block, // block per protective element
    output logic irq // level interrupt
);
    import mcs_pkg::*;

    logic [CTL_W-1:0] ctrl_q;
    logic [15:0] dev_thr_q, ph_pri_q, ph_sec_q, e_pri_q, e_sec_q;
    logic [15:0] vnom_q, i_low_q, i_rated_q, t_alarm_q;
    logic [7:0] kd_q;
    logic [NUM_OC-1:0] oc_mask_q;
    logic [NUM_ELEM-1:0] elem_sup_q;
    logic [EV_W-1:0] evt_q, mask_q, evt_src, evt_prev_q;
    logic [31:0] rd_d;
    logic hit, wr_en, cfg_ratio_wr, ratio_start_q;

    // pins from outside the clock domain: two flip-flops each
    logic [2:0] pin_meta_q, pin_sync_q, pin_raw;
    assign pin_raw = {earth_vt_fuse_input, phase_vt_fuse_input, breaker_closed};
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_meta_q[g] <= 1'b0;
                    pin_sync_q[g] <= 1'b0;
                end else begin
                    pin_meta_q[g] <= pin_raw[g];
                    pin_sync_q[g] <= pin_meta_q[g];
                end
            end
        end
    endgenerate

    // apb slave: zero wait states, read data captured in the setup cycle
    assign wr_en = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RESET;
            dev_thr_q <= '0;
            kd_q <= '0;
            ph_pri_q <= RATING_RESET;
            ph_sec_q <= RATING_RESET;
            e_pri_q <= RATING_RESET;
            e_sec_q <= RATING_RESET;
            vnom_q <= '0;
            i_low_q <= '0;
            i_rated_q <= '0;
            t_alarm_q <= '0;
            oc_mask_q <= '0;
            elem_sup_q <= '0;
            mask_q <= '0;
        end else if (wr_en) begin
            unique case (paddr)
                OFF_CTRL: ctrl_q <= pwdata[CTL_W-1:0];
                OFF_DEV_THR: dev_thr_q <= pwdata[15:0];
                OFF_KD: kd_q <= pwdata[7:0];
                OFF_PH_PRI: ph_pri_q <= pwdata[15:0];
                OFF_PH_SEC: ph_sec_q <= pwdata[15:0];
                OFF_E_PRI: e_pri_q <= pwdata[15:0];
                OFF_E_SEC: e_sec_q <= pwdata[15:0];
                OFF_VNOM: vnom_q <= pwdata[15:0];
                OFF_I_LOW: i_low_q <= pwdata[15:0];
                OFF_I_RATED: i_rated_q <= pwdata[15:0];
                OFF_T_ALARM: t_alarm_q <= pwdata[15:0];
                OFF_OC_MASK: oc_mask_q <= pwdata[NUM_OC-1:0];
                OFF_ELEM_SUP: elem_sup_q <= pwdata[NUM_ELEM-1:0];
                OFF_MASK: mask_q <= pwdata[EV_W-1:0];
                default: ;
            endcase
        end
    end

    // ratio factor recomputed from ct ratings
    // ki = (e_pri/e_sec) / (ph_pri/ph_sec), redone after any rating write or reset
    assign cfg_ratio_wr = wr_en && (paddr == OFF_PH_PRI || paddr == OFF_PH_SEC ||
                                    paddr == OFF_E_PRI || paddr == OFF_E_SEC);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ratio_start_q <= 1'b1;
        end else begin
            ratio_start_q <= cfg_ratio_wr;
        end
    end

    logic [31:0] ratio_num_hi, ratio_den;
    logic [15:0] ki_div;
    logic ratio_busy, ratio_done, ki_valid_q;
    logic [15:0] ratio_correction_factor;
    assign ratio_num_hi = e_pri_q * ph_sec_q;
    assign ratio_den = e_sec_q * ph_pri_q;

    mcs_ratio_div #(.NW(32 + KI_FRAC), .DW(32), .QW(16)) u_ratio (
        .pclk(pclk),
        .presetn(presetn),
        .start(ratio_start_q),
        .num({ratio_num_hi, {KI_FRAC{1'b0}}}),
        .den(ratio_den),
        .busy(ratio_busy),
        .done(ratio_done),
        .quot(ki_div)
    );

    // the old factor stays in use while a new one is computed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ki_valid_q <= 1'b0;
        end else if (ratio_done) begin
            ki_valid_q <= 1'b1;
        end
    end
    assign ratio_correction_factor = ki_valid_q ? ki_div : KI_RESET;

    // ct supervision, squared magnitudes avoid a square root
    logic signed [17:0] res3_re, res3_im;
    logic signed [32:0] kig_re_full, kig_im_full;
    logic signed [25:0] sum_re, sum_im;
    logic [51:0] sq_re, sq_im;
    logic [52:0] mismatch_sq, limit_sq;
    logic [15:0] imax, kd_term;
    logic [23:0] kd_prod;
    logic [16:0] limit;
    logic cts_fail_q;

    assign res3_re = 18'(i0_re) * RESID_MULT;
    assign res3_im = 18'(i0_im) * RESID_MULT;
    assign kig_re_full = $signed({1'b0, ratio_correction_factor}) * earth_re;
    assign kig_im_full = $signed({1'b0, ratio_correction_factor}) * earth_im;
    assign sum_re = 26'(res3_re) + 26'($signed(kig_re_full[32:KI_FRAC]));
    assign sum_im = 26'(res3_im) + 26'($signed(kig_im_full[32:KI_FRAC]));
    assign sq_re = 52'(sum_re * sum_re);
    assign sq_im = 52'(sum_im * sum_im);
    assign mismatch_sq = 53'(sq_re) + 53'(sq_im);

    assign imax = (ia >= ib) ? ((ia >= ic) ? ia : ic) : ((ib >= ic) ? ib : ic);
    assign kd_prod = kd_q * imax;
    assign kd_term = kd_prod[23:KD_FRAC];
    assign limit = 17'(dev_thr_q) + 17'(kd_term);
    assign limit_sq = 53'(limit * limit);

    // failure at or above the limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cts_fail_q <= 1'b0;
        end else begin
            cts_fail_q <= ctrl_q[CTL_CTS_EN] && (mismatch_sq >= limit_sq);
        end
    end
    assign cts_alarm = cts_fail_q;

    // loss of potential from measured quantities
    logic [23:0] vn24;
    logic c_volt, c_seq, c_curr, c_resid, c_oc, c_brk, c_live, lop_cond;
    logic [43:0] i0_sq;
    assign vn24 = 24'(vnom_q);
    assign c_volt = (24'(va) * VNOM_DIV < vn24) || (24'(vb) * VNOM_DIV < vn24) ||
                    (24'(vc) * VNOM_DIV < vn24);
    assign c_seq = (24'(v_resid) * VNOM_DIV < vn24) ||
                   (24'(v_neg) * PCT_FULL > 24'(v_pos) * NEG_SEQ_PCT);
    assign c_curr = (ia < i_low_q) && (ib < i_low_q) && (ic < i_low_q);
    // residual current below a tenth of rated
    assign i0_sq = 44'(res3_re * res3_re) + 44'(res3_im * res3_im);
    assign c_resid = i0_sq * I_RATED_DIV < 44'(i_rated_q * i_rated_q);
    assign c_oc = ((oc_pickup & oc_mask_q) == '0);
    assign c_brk = !ctrl_q[CTL_BRK_ASSIGN] || pin_sync_q[0];
    assign c_live = !dead_bus;
    assign lop_cond = c_volt && c_seq && c_curr && c_resid && c_oc && c_brk && c_live;

    // alarm delay in units of UNIT_CYCLES clocks
    localparam int PW = $clog2(UNIT_CYCLES + 1);
    logic [PW-1:0] pre_q;
    logic [15:0] lop_cnt_q;
    logic unit_tick, lop_alarm_q;
    assign unit_tick = (pre_q == PW'(UNIT_CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= '0;
            lop_cnt_q <= '0;
        end else if (!lop_cond) begin
            pre_q <= '0;
            lop_cnt_q <= '0;
        end else if (lop_cnt_q < t_alarm_q) begin
            pre_q <= unit_tick ? '0 : pre_q + 1'b1;
            if (unit_tick) begin
                lop_cnt_q <= lop_cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lop_alarm_q <= 1'b0;
        end else begin
            lop_alarm_q <= lop_cond && (lop_cnt_q >= t_alarm_q);
        end
    end
    assign potential_loss_block = lop_alarm_q;

    // blocking of supervised elements
    logic vt_fuse_act, evt_fuse_act, block_cmd;
    assign vt_fuse_act = ctrl_q[CTL_VT_FUSE_ASSIGN] && pin_sync_q[1];
    assign evt_fuse_act = ctrl_q[CTL_EVT_FUSE_ASSIGN] && pin_sync_q[2];
    assign block_cmd = (lop_alarm_q && ctrl_q[CTL_BLOCK_EN]) || vt_fuse_act || evt_fuse_act;
    generate
        for (g = 0; g < NUM_ELEM; g++) begin : g_elem
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    elem_block[g] <= 1'b0;
                end else begin
                    elem_block[g] <= block_cmd && elem_sup_q[g];
                end
            end
        end
    endgenerate

    // events on rising edges; a set in the clearing cycle wins
    assign evt_src = {evt_fuse_act, vt_fuse_act, lop_alarm_q, cts_fail_q};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_prev_q <= '0;
            evt_q <= '0;
        end else begin
            evt_prev_q <= evt_src;
            evt_q <= (evt_q & ~((wr_en && paddr == OFF_EVENT) ? pwdata[EV_W-1:0] : '0))
                     | (evt_src & ~evt_prev_q);
        end
    end
    assign irq = |(evt_q & mask_q);

    // read mux
    always_comb begin
        rd_d = '0;
        hit = 1'b1;
        unique case (paddr)
            OFF_CTRL: rd_d[CTL_W-1:0] = ctrl_q;
            OFF_DEV_THR: rd_d[15:0] = dev_thr_q;
            OFF_KD: rd_d[7:0] = kd_q;
            OFF_PH_PRI: rd_d[15:0] = ph_pri_q;
            OFF_PH_SEC: rd_d[15:0] = ph_sec_q;
            OFF_E_PRI: rd_d[15:0] = e_pri_q;
            OFF_E_SEC: rd_d[15:0] = e_sec_q;
            OFF_VNOM: rd_d[15:0] = vnom_q;
            OFF_I_LOW: rd_d[15:0] = i_low_q;
            OFF_I_RATED: rd_d[15:0] = i_rated_q;
            OFF_T_ALARM: rd_d[15:0] = t_alarm_q;
            OFF_OC_MASK: rd_d[NUM_OC-1:0] = oc_mask_q;
            OFF_ELEM_SUP: rd_d[NUM_ELEM-1:0] = elem_sup_q;
            OFF_STATUS: rd_d[ST_W-1:0] = {ratio_busy, block_cmd, lop_cond,
                                          evt_src};
            OFF_EVENT: rd_d[EV_W-1:0] = evt_q;
            OFF_MASK: rd_d[EV_W-1:0] = mask_q;
            OFF_KI: rd_d[15:0] = ratio_correction_factor;
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_d;
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_cts_detect: assert property (ctrl_q[CTL_CTS_EN] && mismatch_sq >= limit_sq |=> cts_alarm)
        else $error("ct failure not flagged at limit");
    a_cts_quiet: assert property (mismatch_sq < limit_sq |=> !cts_alarm)
        else $error("ct failure flagged below limit");
    a_lop_all_cond: assert property (potential_loss_block |-> $past(lop_cond))
        else $error("block without full condition set");
    a_lop_restart: assert property (!lop_cond |=> lop_cnt_q == '0 && !potential_loss_block)
        else $error("delay not restarted on dropout");
    a_lop_delay: assert property ($rose(potential_loss_block) |-> $past(lop_cnt_q) >= t_alarm_q)
        else $error("alarm before delay expired");
    a_brk_open: assert property (ctrl_q[CTL_BRK_ASSIGN] && !pin_sync_q[0]
                                 |=> !potential_loss_block)
        else $error("detection with assigned breaker open");
    a_block_enable: assert property (!ctrl_q[CTL_BLOCK_EN] && !vt_fuse_act && !evt_fuse_act
                                     |=> elem_block == '0)
        else $error("block without enable or fuse");
    a_fuse_block: assert property ($rose(vt_fuse_act) || $rose(evt_fuse_act)
                                   |=> elem_block == elem_sup_q)
        else $error("fuse failure did not block elements");
    a_elem_optin: assert property ((elem_block & ~$past(elem_sup_q)) == '0)
        else $error("unsupervised element blocked");
    a_oc_pickup: assert property ((oc_pickup & oc_mask_q) != '0
                                  |=> !potential_loss_block)
        else $error("detection despite overcurrent pickup");

    c_lop_alarm: cover property ($rose(potential_loss_block));
    c_cts_alarm: cover property ($rose(cts_alarm));
    c_fuse_block: cover property ($rose(evt_fuse_act) ##1 elem_block != '0);
    c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// ===== test/mcs_meas_model.sv
// Purpose: measuring chain stand-in for ct and vt quantities
// Assumes: fault names the potential loss condition to break, 7 breaks none
// Notes: outputs are registered so they move just after an edge
`timescale 1ns/1ps
`default_nettype none
module mcs_meas_model (
    input wire logic pclk, // block clock
    input wire logic [2:0] fault, // condition to break
    input wire logic signed [15:0] i0v, // zero-sequence current to apply
    input wire logic signed [15:0] egv, // earth current to apply
    input wire logic [15:0] iav, // phase a current to apply
    output logic signed [15:0] i0_re, // zero-sequence, real
    output logic signed [15:0] i0_im, // zero-sequence, imaginary
    output logic signed [15:0] earth_re, // earth current, real
    output logic signed [15:0] earth_im, // earth current, imaginary
    output logic [15:0] ia, // phase a current
    output logic [15:0] ib, // phase b current
    output logic [15:0] ic, // phase c current
    output logic [15:0] va, // phase a voltage
    output logic [15:0] vb, // phase b voltage
    output logic [15:0] vc, // phase c voltage
    output logic [15:0] v_resid, // residual voltage
    output logic [15:0] v_pos, // positive sequence voltage
    output logic [15:0] v_neg, // negative sequence voltage
    output logic [7:0] oc_pickup, // overcurrent pickups
    output logic dead_bus, // dead busbar
    output logic breaker_closed // breaker closed
);
    always_ff @(posedge pclk) begin
        i0_re <= (fault == 3'h6) ? 16'sh0014 : i0v;
        i0_im <= 16'sh0000;
        earth_re <= egv;
        earth_im <= 16'sh0000;
        ia <= (fault == 3'h2) ? 16'h003c : iav;
        ib <= 16'h000a;
        ic <= 16'h000a;
        va <= (fault == 3'h0) ? 16'h03e8 : 16'h0005;
        vb <= 16'h03e8;
        vc <= 16'h03e8;
        v_resid <= (fault == 3'h1) ? 16'h03e8 : 16'h0005;
        v_pos <= 16'h03e8;
        v_neg <= 16'h0000;
        oc_pickup <= {7'h00, fault == 3'h3};
        dead_bus <= (fault == 3'h4);
        breaker_closed <= (fault != 3'h5);
    end
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Purpose: self-checking bench for the supervision block
// Assumes: unit of the alarm delay shrunk to 4 cycles
// Notes: a read just after an edge sees what was settled before it
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; $display("mismatch at %0t: got %h", $time, a); end end
module testbench;
    import mcs_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, re;
    logic [7:0] paddr = 8'h00, oc_pickup, elem_block;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic pready, pslverr, cts_alarm, potential_loss_block, irq, dead_bus, breaker_closed;
    logic phase_vt_fuse_input = 0, earth_vt_fuse_input = 0;
    logic [2:0] fault = 3'h7;
    logic signed [15:0] i0v = 16'sh0, egv = 16'sh0, i0_re, i0_im, earth_re, earth_im;
    logic [15:0] iav = 16'h000a, ia, ib, ic, va, vb, vc, v_resid, v_pos, v_neg;
    int mismatches = 0, n_checks = 0, kd, t;
    mcs_meas_model meas_u (.*);
    mcs_top #(.UNIT_CYCLES(4)) dut_u (.*);
    initial forever #50 pclk = ~pclk;
    initial begin
        #2000000;
        mismatches++;
        complete_run();
    end
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // ratings are equal here, so the ratio factor is one and the earth term adds as is
    function automatic logic exp_cts(int i0, int eg, int k, int im);
        int s;
        s = 3 * i0 + eg;
        if (s < 0) s = -s;
        return s >= 99 + ((k * im) >> KD_FRAC);
    endfunction
    initial begin
        wt(3);
        presetn <= 1'b1;
        t = $urandom(52);
        wt(60);
        apb(0, 8'h80, 0);
        `CHK(re, 1'b1)
        `CHK(rv, 32'h0)
        apb(0, OFF_KI, 0);
        `CHK(rv, 32'h100)
        apb(1, OFF_E_PRI, 2);
        wt(60);
        apb(0, OFF_KI, 0);
        `CHK(rv, 32'h200)
        apb(1, OFF_E_PRI, 1);
        apb(1, OFF_DEV_THR, 99);
        // three phase cts and a separate earth ct are modelled, so enable
        apb(1, OFF_CTRL, 1);
        wt(60);
        for (int k = 0; k < 14; k++) begin
            i0v <= (k == 0) ? 16'sd33 : (k == 1) ? 16'sd32 :
                   (k == 2) ? 16'sd40 : 16'($urandom % 60);
            // a negative earth current brings the sum down exactly onto the limit
            egv <= (k == 2) ? -16'sd21 : (k < 2) ? 16'sd0 : 16'(int'($urandom % 120) - 60);
            iav <= (k < 3) ? 16'd10 : 16'(10 + $urandom % 190);
            kd = (k < 3) ? 0 : $urandom % 256;
            apb(1, OFF_KD, kd);
            wt(3);
            `CHK(cts_alarm, exp_cts(i0v, egv, kd, iav))
        end
        fault <= 3'h0;
        i0v <= 16'sh0;
        egv <= 16'sh0;
        iav <= 16'h000a;
        apb(1, OFF_VNOM, 1000);
        apb(1, OFF_I_LOW, 50);
        apb(1, OFF_I_RATED, 100);
        // delay kept well short of any element trip delay
        apb(1, OFF_T_ALARM, 2);
        apb(1, OFF_OC_MASK, 1);
        apb(1, OFF_ELEM_SUP, 15);
        apb(1, OFF_CTRL, 6);
        for (int k = 0; k < 7; k++) begin
            // the breaker pin passes two sync flops, so it lags two cycles both ways
            fault <= 3'h7;
            wt(6);
            `CHK(potential_loss_block, 1'b0)
            wt(8);
            `CHK(potential_loss_block, 1'b1)
            `CHK(elem_block, 8'h0f)
            fault <= 3'(k);
            wt(6);
            `CHK(potential_loss_block, 1'b0)
            `CHK(elem_block, 8'h00)
        end
        fault <= 3'h7;
        apb(1, OFF_CTRL, 4);
        wt(12);
        `CHK(potential_loss_block, 1'b1)
        `CHK(elem_block, 8'h00)
        apb(1, OFF_CTRL, 0);
        fault <= 3'h5;
        wt(4);
        `CHK(potential_loss_block, 1'b1)
        fault <= 3'h0;
        apb(1, OFF_EVENT, 15);
        apb(1, OFF_MASK, 4);
        apb(1, OFF_CTRL, 8);
        phase_vt_fuse_input <= 1'b1;
        wt(5);
        `CHK(elem_block, 8'h0f)
        `CHK(irq, 1'b1)
        phase_vt_fuse_input <= 1'b0;
        wt(5);
        `CHK(elem_block, 8'h00)
        `CHK(irq, 1'b1)
        apb(1, OFF_EVENT, 4);
        wt(1);
        `CHK(irq, 1'b0)
        apb(1, OFF_CTRL, 16);
        earth_vt_fuse_input <= 1'b1;
        wt(5);
        `CHK(elem_block, 8'h0f)
        `CHK(irq, 1'b0)
        apb(0, OFF_EVENT, 0);
        `CHK(rv[3], 1'b1)
        complete_run();
    end
endmodule
`default_nettype wire
